//--- sim/adc_serial_port_asserts.sv
// checker for the serial result port, bound to its top module
`default_nettype none
module adc_serial_port_asserts #(
	parameter SCLK_HALF = 4
) (
	// clock, reset, bus and engine
	input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, conv_busy_i, result_load_i,
	// shared pins and serial link
	input wire logic parallel_bit_six_i, parallel_bit_seven_i, parallel_bit_six_oe_o,
	input wire logic parallel_bit_seven_oe_o, parallel_bit_eight_oe_o, parallel_bit_nine_oe_o,
	input wire logic sclk_i, sclk_o, sclk_oe_o, serial_result_out_o, sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// polarity strap delayed as the block sees it, and the frame it implies
	logic [1:0] pol_q;
	always @(posedge clk_i) pol_q <= {pol_q[0], parallel_bit_seven_i};
	wire ser = !parallel_bit_six_oe_o;
	wire frm = ser & (sync_o ^ pol_q[1]);
	property p_oe;
		{parallel_bit_six_oe_o, parallel_bit_seven_oe_o, parallel_bit_eight_oe_o,
			parallel_bit_nine_oe_o} inside {4'h0, 4'hF};
	endproperty
	a_oe: assert property (p_oe) else $error("pin enables split");
	property p_sync; !ser |-> !sync_o; endproperty
	a_sync: assert property (p_sync) else $error("sync outside serial");
	property p_sclk_oe; sclk_oe_o |-> ser && !$past(parallel_bit_six_i, 2); endproperty
	a_sclk_oe: assert property (p_sclk_oe) else $error("clock driven as slave");
	property p_tog; $changed(sclk_o) && sclk_oe_o |=> $stable(sclk_o) [*3]; endproperty
	a_tog: assert property (p_tog) else $error("clock half period");
	property p_start;
		$rose(frm) |-> $past(result_load_i) || ($past(conv_busy_i) && !$past(conv_busy_i, 2));
	endproperty
	a_start: assert property (p_start) else $error("frame without start");
	property p_len; $rose(frm) && sclk_oe_o |-> ##130 frm ##[1:20] !frm; endproperty
	a_len: assert property (p_len) else $error("frame length");
	property p_upd;
		ser && !sclk_oe_o && $changed(serial_result_out_o) |->
			$past(result_load_i) || $past(sclk_i, 3) != $past(sclk_i, 4);
	endproperty
	a_upd: assert property (p_upd) else $error("data off clock edge");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus answer");
	c_master: cover property ($rose(frm) && sclk_oe_o);
	c_slave: cover property ($rose(frm) && !sclk_oe_o);
	c_ack: cover property (wb_ack_o);
endmodule // adc_serial_port_asserts
bind adc_serial_port adc_serial_port_asserts #(.SCLK_HALF(SCLK_HALF)) chk (.*);
`default_nettype wire

//--- sim/adc_serial_port_tb.sv
// self-checking bench for the serial result port
`default_nettype none
`include "adc_serial_regs.vh"
module adc_serial_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [17:0] RV = 18'h2A5C3;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic conv_busy_i = 1'b0, result_load_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, strap = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, q;
	logic [17:0] result_i = 18'h0, cap;
	int err_count = 0, num_checks = 0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, sclk_i, sclk_o, sclk_oe_o, serial_result_out_o, sync_o;
	wire parallel_bit_six_o, parallel_bit_seven_o, parallel_bit_eight_o, parallel_bit_nine_o;
	wire parallel_bit_six_oe_o, parallel_bit_seven_oe_o, parallel_bit_eight_oe_o;
	wire parallel_bit_nine_oe_o, parallel_bit_six_i, parallel_bit_seven_i;
	wire parallel_bit_eight_i, parallel_bit_nine_i;
	// pin level: the block when it drives, the host strap otherwise
	assign parallel_bit_six_i = parallel_bit_six_oe_o ? parallel_bit_six_o : strap[0];
	assign parallel_bit_seven_i = parallel_bit_seven_oe_o ? parallel_bit_seven_o : strap[1];
	assign parallel_bit_eight_i = parallel_bit_eight_oe_o ? parallel_bit_eight_o : strap[2];
	assign parallel_bit_nine_i = parallel_bit_nine_oe_o ? parallel_bit_nine_o : strap[3];
	adc_serial_port DUT (.*);
	host_model host (.sclk_o, .sclk_oe_o, .sdo(serial_result_out_o), .inv(strap[2]), .sclk_i,
		.cap);
	initial forever #4 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one classic bus cycle, held until the answer
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	// straps move only while the block drives the shared pins
	task automatic cfg(input logic [3:0] s, input logic [31:0] c);
		wb(1, `REG_CTRL, 32'h4);
		strap <= s;
		repeat (3) @(posedge clk_i);
		wb(1, `REG_CTRL, c);
		repeat (3) @(posedge clk_i);
	endtask
	task automatic load(input logic [17:0] r);
		@(posedge clk_i);
		{result_i, result_load_i} <= {r, 1'b1};
		@(posedge clk_i);
		result_load_i <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic idle(input logic p);
		repeat (400) if (sync_o !== p) @(posedge clk_i);
		chk(sync_o, p);
	endtask
	task automatic t_par();
		wb(0, `REG_CTRL, 0);
		chk(q, 32'h4);
		wb(0, 4'hC, 0);
		chk(q, 0);
		load(RV);
		chk({parallel_bit_nine_o, parallel_bit_eight_o, parallel_bit_seven_o,
			parallel_bit_six_o}, RV[9:6]);
		chk(parallel_bit_six_oe_o, 1);
		wb(1, `REG_CTRL, 0);
		wb(0, `REG_RESULT, 0);
		chk(q, RV ^ 18'h20000);
	endtask
	task automatic t_master(input logic p, i);
		cfg({1'b0, i, p, 1'b0}, 32'h7);
		chk({sclk_oe_o, sync_o, sclk_o}, {1'b1, p, i});
		conv_busy_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(sync_o, p);
		conv_busy_i <= 1'b0;
		load(RV);
		chk(sync_o, !p);
		idle(p);
		chk(cap, RV);
		cfg({1'b1, i, p, 1'b0}, 32'h7);
		conv_busy_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(sync_o, !p);
		idle(p);
		chk(cap, RV);
		conv_busy_i <= 1'b0;
	endtask
	task automatic t_slave(input logic i);
		cfg({1'b1, i, 2'b01}, 32'h3);
		chk(sclk_oe_o, 0);
		load(RV);
		host.burst();
		idle(1'b0);
		chk(cap, RV ^ 18'h20000);
		host.burst();
		chk(cap, 18'h3FFFF);
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_par();
		t_master(1'b0, 1'b0);
		t_master(1'b1, 1'b1);
		t_slave(1'b0);
		t_slave(1'b1);
		test_done();
	end
	// watchdog against a hang
	initial begin
		#60000;
		err_count++;
		test_done();
	end
endmodule // adc_serial_port_tb
`default_nettype wire

//--- sim/host_model.sv
// host model: link clock source in slave mode and bit capture
`default_nettype none
module host_model (
	// link from the block, and the clock invert strap
	input wire logic sclk_o, sclk_oe_o, sdo, inv,
	// link clock level and captured bits
	output wire logic sclk_i,
	output logic [17:0] cap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic k = 1'b1; // host clock phase, rests high between reads
	wire sk = (sclk_oe_o ? sclk_o : sclk_i) ^ inv;
	// as slave the host makes the clock, in the sense the invert strap asks
	assign sclk_i = sclk_oe_o ? sclk_o : k ^ inv;
	// sample where data is valid: internal rise as master, fall as slave
	always @(sk)
		if (sk == sclk_oe_o) cap <= {cap[16:0], sdo};
	// one read of 18 link clocks at 80 ns, then the clock stands still
	task automatic burst();
		repeat (18) begin
			#40 k = 1'b0;
			#40 k = 1'b1;
		end
	endtask
endmodule // host_model
`default_nettype wire

//--- src/adc_serial_port.v
// serial result port with shared parallel bits six to nine and a wishbone register file
//
// Operation
// - outside serial mode the four shared pins drive parallel result bits 6, 7, 8 and 9.
// - in serial mode with clock source low the block makes the serial clock and drives it out.
// - in serial mode with clock source high the host supplies the clock and data follows it.
// - the frame sync is active high with polarity select low and active low with it high.
// - the clock invert select reverses the serial clock sense in master and slave operation.
// - the shared read-mode/chain pin is a chain input or a read mode select by clock source.
// - with external clock the chain input level reappears on the output 17 clocks later.
// - with internal clock a high read mode shifts during conversion, low only after it.
// - with external clock output changes on the rising edge, or the falling edge if inverted.
// - each result leaves its shift register msb first in the selected coding.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`include "adc_serial_regs.vh"
`default_nettype none

module adc_serial_port #(
	parameter RESULT_BITS = `RESULT_BITS,
	parameter SCLK_HALF = `SCLK_HALF_CYCLES
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output wire wb_ack_o,
	// conversion engine
	input wire conv_busy_i,
	input wire result_load_i,
	input wire [RESULT_BITS-1:0] result_i,
	// shared pin: parallel bit six or clock source select
	input wire parallel_bit_six_i,
	output wire parallel_bit_six_o,
	output wire parallel_bit_six_oe_o,
	// shared pin: parallel bit seven or sync polarity select
	input wire parallel_bit_seven_i,
	output wire parallel_bit_seven_o,
	output wire parallel_bit_seven_oe_o,
	// shared pin: parallel bit eight or serial clock invert
	input wire parallel_bit_eight_i,
	output wire parallel_bit_eight_o,
	output wire parallel_bit_eight_oe_o,
	// shared pin: parallel bit nine or read mode / chain input
	input wire parallel_bit_nine_i,
	output wire parallel_bit_nine_o,
	output wire parallel_bit_nine_oe_o,
	// serial link
	input wire sclk_i,
	output wire sclk_o,
	output wire sclk_oe_o,
	output reg serial_result_out_o,
	output wire sync_o
);

	localparam integer LAST_IDX = RESULT_BITS - 1;
	localparam [4:0] LAST_BIT = LAST_IDX[4:0];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire [4:0] pins_sync;
	wire serial_clock_source_select;
	wire sync_polarity_select;
	wire serial_clock_invert;
	wire read_mode_or_chain_input;
	wire sclk_sync;

	pin_sync #(.WIDTH(5)) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({sclk_i, parallel_bit_nine_i, parallel_bit_eight_i,
			parallel_bit_seven_i, parallel_bit_six_i}),
		.sync_o(pins_sync)
	);

	assign serial_clock_source_select = pins_sync[0];
	assign sync_polarity_select = pins_sync[1];
	assign serial_clock_invert = pins_sync[2];
	assign read_mode_or_chain_input = pins_sync[3];
	assign sclk_sync = pins_sync[4];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [1:0] mode_reg;
	reg coding_reg;
	reg ack_reg;
	reg [RESULT_BITS-1:0] result_reg;
	reg [RESULT_BITS-2:0] shift_reg; // result bits below the msb, then chained bits
	reg [4:0] bit_cnt_reg;
	reg frame_reg;
	reg sclk_int_reg;
	reg [7:0] div_cnt_reg;
	reg sclk_prev_reg;
	reg busy_prev_reg;

	wire serial_mode;
	wire slave_mode;
	wire [RESULT_BITS-1:0] coded_result;
	wire busy_rise;
	wire read_start;
	wire ext_rise;
	wire ext_fall;
	wire ext_update;
	wire div_hit;
	wire master_fall;
	wire wb_req;

	assign serial_mode = (mode_reg == `MODE_SERIAL);
	assign slave_mode = serial_clock_source_select;
	assign wb_req = wb_cyc_i & wb_stb_i;

	// straight binary when coding select is high, msb inverted otherwise
	assign coded_result = coding_reg ? result_reg :
		{~result_reg[RESULT_BITS-1], result_reg[RESULT_BITS-2:0]};

	// ----------------------------------------------------------------
	// read start selection
	// ----------------------------------------------------------------
	assign busy_rise = conv_busy_i & ~busy_prev_reg;
	// master reads during conversion on a high read mode, after it on low
	assign read_start = serial_mode & ((~slave_mode & read_mode_or_chain_input) ?
		busy_rise : result_load_i);

	// ----------------------------------------------------------------
	// edges of the external clock and of the internal divider
	// ----------------------------------------------------------------
	assign ext_rise = sclk_sync & ~sclk_prev_reg;
	assign ext_fall = ~sclk_sync & sclk_prev_reg;
	assign ext_update = serial_clock_invert ? ext_fall : ext_rise;
	assign div_hit = (div_cnt_reg == SCLK_HALF - 1);
	assign master_fall = frame_reg & div_hit & sclk_int_reg;

	// conversion result store and edge history
	always @(posedge clk_i) begin
		if (rst_i) begin
			result_reg <= {RESULT_BITS{1'b0}};
			busy_prev_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
		end else begin
			busy_prev_reg <= conv_busy_i;
			sclk_prev_reg <= sclk_sync;
			if (result_load_i) begin
				result_reg <= result_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg <= {(RESULT_BITS-1){1'b0}};
			bit_cnt_reg <= 5'h00;
			frame_reg <= 1'b0;
			sclk_int_reg <= 1'b0;
			div_cnt_reg <= 8'h00;
			serial_result_out_o <= 1'b0;
		end else if (read_start & ~frame_reg) begin
			// present msb at frame start; the rest stands one stage behind it, so a
			// chained bit follows the lsb directly, 18 edges into the read
			shift_reg <= coded_result[RESULT_BITS-2:0];
			serial_result_out_o <= coded_result[RESULT_BITS-1];
			bit_cnt_reg <= 5'h00;
			frame_reg <= 1'b1;
			sclk_int_reg <= 1'b0;
			div_cnt_reg <= 8'h00;
		end else if (serial_mode & slave_mode) begin
			// slave: shift on the update edge, chain input fills from behind
			if (ext_update) begin
				serial_result_out_o <= shift_reg[RESULT_BITS-2];
				shift_reg <= {shift_reg[RESULT_BITS-3:0], read_mode_or_chain_input};
				if (frame_reg) begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == LAST_BIT) begin
						frame_reg <= 1'b0;
					end
				end
			end
		end else if (serial_mode & frame_reg) begin
			// master: divide the clock, move data on internal falling edges
			div_cnt_reg <= div_hit ? 8'h00 : div_cnt_reg + 8'h01;
			if (div_hit) begin
				sclk_int_reg <= ~sclk_int_reg;
			end
			if (master_fall) begin
				serial_result_out_o <= shift_reg[RESULT_BITS-2];
				shift_reg <= {shift_reg[RESULT_BITS-3:0], 1'b0};
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
				if (bit_cnt_reg == LAST_BIT) begin
					frame_reg <= 1'b0;
				end
			end
		end else if (~serial_mode) begin
			frame_reg <= 1'b0;
			sclk_int_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// outside serial mode the shared pins carry parallel result bits
	assign parallel_bit_six_o = coded_result[6];
	assign parallel_bit_seven_o = coded_result[7];
	assign parallel_bit_eight_o = coded_result[8];
	assign parallel_bit_nine_o = coded_result[9];
	assign parallel_bit_six_oe_o = ~serial_mode;
	assign parallel_bit_seven_oe_o = ~serial_mode;
	assign parallel_bit_eight_oe_o = ~serial_mode;
	assign parallel_bit_nine_oe_o = ~serial_mode;

	// master clock out, inverted on request
	assign sclk_o = sclk_int_reg ^ serial_clock_invert;
	assign sclk_oe_o = serial_mode & ~slave_mode;
	// frame sync polarity
	assign sync_o = serial_mode & (frame_reg ^ sync_polarity_select);

	// ----------------------------------------------------------------
	// wishbone register file
	// ----------------------------------------------------------------
	assign wb_ack_o = ack_reg;

	// one wait state, ack drops after one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			mode_reg <= `CTRL_MODE_RESET;
			coding_reg <= `CTRL_CODING_RESET;
			wb_dat_o <= 32'h00000000;
		end else begin
			ack_reg <= wb_req & ~ack_reg;
			if (wb_req & ~ack_reg) begin
				wb_dat_o <= 32'h00000000;
				if (wb_we_i & wb_sel_i[0] & (wb_adr_i == `REG_CTRL)) begin
					mode_reg <= wb_dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
					coding_reg <= wb_dat_i[`CTRL_CODING_BIT];
				end
				if (~wb_we_i) begin
					case (wb_adr_i)
						`REG_CTRL: begin
							wb_dat_o[`CTRL_MODE_MSB:`CTRL_MODE_LSB] <= mode_reg;
							wb_dat_o[`CTRL_CODING_BIT] <= coding_reg;
						end
						`REG_STATUS: begin
							wb_dat_o[`STAT_FRAME_BIT] <= frame_reg;
							wb_dat_o[`STAT_BUSY_BIT] <= conv_busy_i;
							wb_dat_o[`STAT_STRAP_MSB:`STAT_STRAP_LSB] <= pins_sync[3:0];
						end
						`REG_RESULT: begin
							wb_dat_o[RESULT_BITS-1:0] <= coded_result;
						end
						default: begin
							wb_dat_o <= 32'h00000000;
						end
					endcase
				end
			end
		end
	end

endmodule // adc_serial_port

`default_nettype wire

//--- src/adc_serial_regs.vh
// register offsets, field positions, reset values and counts for the serial result port
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RESULT 4'h8

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_CODING_BIT 2
`define CTRL_MODE_RESET 2'h0
`define CTRL_CODING_RESET 1'h1

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STAT_FRAME_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_STRAP_LSB 4
`define STAT_STRAP_MSB 7

// ----------------------------------------------------------------
// interface mode and counts
// ----------------------------------------------------------------
`define MODE_SERIAL 2'h3
`define RESULT_BITS 18
`define SCLK_HALF_CYCLES 4

`endif

//--- src/pin_sync.v
// two flip-flop synchroniser for inputs from outside the clock domain
`default_nettype none

module pin_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// asynchronous in, synchronised out
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// first stage feeds only the second stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= async_i;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_o = stage2_reg;

endmodule // pin_sync

`default_nettype wire
